// ---- iac_map.vh ----
// Constants for the interrupt-acknowledge capture block.
`ifndef IAC_MAP_VH
`define IAC_MAP_VH
// ------------------------------------------------------------------
// Register indices
// ------------------------------------------------------------------
`define IAC_REG_CTRL 4'h0
`define IAC_REG_STATUS 4'h1
`define IAC_REG_TYPE_NOARM 4'h2
`define IAC_REG_TYPE_REARM 4'h3
`define IAC_REG_CASCADE 4'h4
`define IAC_REG_FORCE 4'h5
`define IAC_REG_IRQ_STAT 4'h6
`define IAC_REG_IRQ_EN 4'h7
`define IAC_REG_IRQ_CLR 4'h8
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define IAC_CTRL_RESP 0
`define IAC_CTRL_SYNC 1
`define IAC_CTRL_RUN 2
`define IAC_ST_CAPT 0
`define IAC_ST_ARMED 1
`define IAC_ST_BUSY 2
`define IAC_ST_LOOP 3
`define IAC_FRC_ONCE 0
`define IAC_FRC_REPEAT 1
`define IAC_FRC_STOP 2
`define IAC_EV_CAPT 0
`define IAC_EV_DONE 1
`define IAC_EV_NUM 2
// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define IAC_ZERO8 8'h00
`define IAC_ZERO32 32'h0000_0000
`define IAC_CYC_LEN 4
`define IAC_GAP_LEN 2
`endif

// ---- iac_capture.v ----
// Interrupt-acknowledge capture, forcing and scope sync logic.
// Summary of operation
// - Respond to requests only while response switched on.
// - Switching on clears flag, type and cascade.
// - Latch type byte from data bus.
// - Rearming type read clears flag, re-enables.
// - Plain type read keeps flag and block.
// - Block acceptance after acknowledge until rearming type read.
// - Latch cascade address from cascade bus.
// - Cascade read changes neither flag nor acceptance.
// - Status read reports the captured flag.
// - Force command runs acknowledge without request.
// - Forced sequence replaces latched type and cascade.
// - Repeat force loops until stopped.
// - Acknowledge sequence is two bus cycles.
// - Sync output low during sequence when selected.
// - Sync spans first cycle start to second end.
// - Common handler outside run mode only.
`include "iac_map.vh"
module iac_capture #(
  parameter CYC_LEN = `IAC_CYC_LEN,
  parameter GAP_LEN = `IAC_GAP_LEN
)(
  input wire i_sys_clk,
  input wire i_rst,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output wire o_irq,
  input wire i_interrupt_request_input,
  input wire [7:0] i_data_bus,
  input wire [2:0] i_cascade_bus,
  output wire o_interrupt_ack_cycle_n,
  output wire o_ack_second_cycle,
  output wire o_scope_sync_n,
  output wire o_common_handler
);
// ------------------------------------------------------------------
// Pin synchronisers
// ------------------------------------------------------------------
reg [1:0] req_sync_q;
reg [7:0] data_s1_q;
reg [7:0] data_s2_q;
reg [2:0] csc_s1_q;
reg [2:0] csc_s2_q;
always @(posedge i_sys_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    req_sync_q <= 2'h0;
    data_s1_q <= `IAC_ZERO8;
    data_s2_q <= `IAC_ZERO8;
    csc_s1_q <= 3'h0;
    csc_s2_q <= 3'h0;
  end
  else
  begin
    req_sync_q <= {req_sync_q[0], i_interrupt_request_input};
    data_s1_q <= i_data_bus;
    data_s2_q <= data_s1_q;
    csc_s1_q <= i_cascade_bus;
    csc_s2_q <= csc_s1_q;
  end
end
wire req_s = req_sync_q[1];
// ------------------------------------------------------------------
// Bus decode
// ------------------------------------------------------------------
function hit;
  input [3:0] a;
  input [3:0] r;
  begin
    hit = (a == r);
  end
endfunction
wire wr_ctrl = i_wr && hit(i_addr, `IAC_REG_CTRL);
wire wr_force = i_wr && hit(i_addr, `IAC_REG_FORCE);
wire wr_ien = i_wr && hit(i_addr, `IAC_REG_IRQ_EN);
wire wr_iclr = i_wr && hit(i_addr, `IAC_REG_IRQ_CLR);
wire read_type_and_rearm = i_rd && hit(i_addr, `IAC_REG_TYPE_REARM);
// ------------------------------------------------------------------
// Control register
// ------------------------------------------------------------------
reg resp_q;
reg sync_sel_q;
reg run_mode_q;
wire resp_on_edge = wr_ctrl && i_wdata[`IAC_CTRL_RESP] && !resp_q;
always @(posedge i_sys_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    resp_q <= 1'b0;
    sync_sel_q <= 1'b0;
    run_mode_q <= 1'b0;
  end
  else if (wr_ctrl)
  begin
    resp_q <= i_wdata[`IAC_CTRL_RESP];
    sync_sel_q <= i_wdata[`IAC_CTRL_SYNC];
    run_mode_q <= i_wdata[`IAC_CTRL_RUN];
  end
end
// Outside run mode every interrupt goes to the common handler.
assign o_common_handler = !run_mode_q;
// ------------------------------------------------------------------
// Acknowledge sequencer
// ------------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_CYC1 = 2'h1;
localparam ST_CYC2 = 2'h2;
localparam ST_GAP = 2'h3;
reg [1:0] st_q;
reg [7:0] cnt_q;
reg loop_q;
reg forced_q;
reg capt_q;
reg armed_q;
reg [7:0] type_q;
reg [2:0] csc_q;
reg done_pulse_q;
reg capt_pulse_q;
wire idle = (st_q == ST_IDLE);
// Requests are taken only when response is on and no type is pending.
wire take_req = idle && resp_q && armed_q && req_s;
wire take_frc = idle && wr_force &&
  (i_wdata[`IAC_FRC_ONCE] || i_wdata[`IAC_FRC_REPEAT]);
wire cyc_end = (cnt_q == CYC_LEN[7:0] - 8'h01);
wire gap_end = (cnt_q == GAP_LEN[7:0] - 8'h01);
always @(posedge i_sys_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    st_q <= ST_IDLE;
    cnt_q <= `IAC_ZERO8;
    loop_q <= 1'b0;
    forced_q <= 1'b0;
    done_pulse_q <= 1'b0;
  end
  else
  begin
    done_pulse_q <= 1'b0;
    if (wr_force && i_wdata[`IAC_FRC_STOP])
      loop_q <= 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        cnt_q <= `IAC_ZERO8;
        if (take_frc)
        begin
          st_q <= ST_CYC1;
          forced_q <= 1'b1;
          loop_q <= i_wdata[`IAC_FRC_REPEAT];
        end
        else if (take_req)
        begin
          st_q <= ST_CYC1;
          forced_q <= 1'b0;
        end
      end
      ST_CYC1:
      begin
        cnt_q <= cyc_end ? `IAC_ZERO8 : cnt_q + 8'h01;
        if (cyc_end)
          st_q <= ST_CYC2;
      end
      ST_CYC2:
      begin
        cnt_q <= cyc_end ? `IAC_ZERO8 : cnt_q + 8'h01;
        if (cyc_end)
        begin
          done_pulse_q <= 1'b1;
          st_q <= ST_GAP;
        end
      end
      ST_GAP:
      begin
        cnt_q <= gap_end ? `IAC_ZERO8 : cnt_q + 8'h01;
        if (gap_end)
        begin
          // A stop written during the gap ends the loop here.
          if (loop_q && !(wr_force && i_wdata[`IAC_FRC_STOP]))
            st_q <= ST_CYC1;
          else
            st_q <= ST_IDLE;
        end
      end
      default:
        st_q <= ST_IDLE;
    endcase
  end
end
wire in_seq = (st_q == ST_CYC1) || (st_q == ST_CYC2);
assign o_interrupt_ack_cycle_n = !in_seq;
assign o_ack_second_cycle = (st_q == ST_CYC2);
assign o_scope_sync_n = !(sync_sel_q && in_seq);
wire latch_now = (st_q == ST_CYC2) && cyc_end;
// ------------------------------------------------------------------
// Capture state
// ------------------------------------------------------------------
always @(posedge i_sys_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    capt_q <= 1'b0;
    armed_q <= 1'b1;
    type_q <= `IAC_ZERO8;
    csc_q <= 3'h0;
    capt_pulse_q <= 1'b0;
  end
  else
  begin
    capt_pulse_q <= latch_now;
    if (latch_now)
    begin
      // Forced and requested sequences both overwrite the latches.
      type_q <= data_s2_q;
      csc_q <= csc_s2_q;
      capt_q <= 1'b1;
      armed_q <= 1'b0;
    end
    else if (resp_on_edge)
    begin
      type_q <= `IAC_ZERO8;
      csc_q <= 3'h0;
      capt_q <= 1'b0;
      armed_q <= 1'b1;
    end
    else if (read_type_and_rearm)
    begin
      capt_q <= 1'b0;
      armed_q <= 1'b1;
    end
  end
end
// ------------------------------------------------------------------
// Interrupt status
// ------------------------------------------------------------------
reg [`IAC_EV_NUM-1:0] ist_q;
reg [`IAC_EV_NUM-1:0] ien_q;
wire [`IAC_EV_NUM-1:0] ev = {done_pulse_q, capt_pulse_q};
always @(posedge i_sys_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    ist_q <= {`IAC_EV_NUM{1'b0}};
    ien_q <= {`IAC_EV_NUM{1'b0}};
  end
  else
  begin
    // A new event beats a clear written in the same cycle.
    if (wr_iclr)
      ist_q <= (ist_q & ~i_wdata[`IAC_EV_NUM-1:0]) | ev;
    else
      ist_q <= ist_q | ev;
    if (wr_ien)
      ien_q <= i_wdata[`IAC_EV_NUM-1:0];
  end
end
assign o_irq = |(ist_q & ien_q);
// ------------------------------------------------------------------
// Read data
// ------------------------------------------------------------------
always @(posedge i_sys_clk or posedge i_rst)
begin
  if (i_rst)
    o_rdata <= `IAC_ZERO32;
  else if (i_rd)
  begin
    o_rdata <= `IAC_ZERO32;
    case (i_addr)
      `IAC_REG_CTRL:
      begin
        o_rdata[`IAC_CTRL_RESP] <= resp_q;
        o_rdata[`IAC_CTRL_SYNC] <= sync_sel_q;
        o_rdata[`IAC_CTRL_RUN] <= run_mode_q;
      end
      `IAC_REG_STATUS:
      begin
        o_rdata[`IAC_ST_CAPT] <= capt_q;
        o_rdata[`IAC_ST_ARMED] <= armed_q;
        o_rdata[`IAC_ST_BUSY] <= !idle;
        o_rdata[`IAC_ST_LOOP] <= loop_q;
      end
      `IAC_REG_TYPE_NOARM: o_rdata[7:0] <= type_q;
      `IAC_REG_TYPE_REARM: o_rdata[7:0] <= type_q;
      `IAC_REG_CASCADE: o_rdata[2:0] <= csc_q;
      `IAC_REG_IRQ_STAT: o_rdata[`IAC_EV_NUM-1:0] <= ist_q;
      `IAC_REG_IRQ_EN: o_rdata[`IAC_EV_NUM-1:0] <= ien_q;
      default: o_rdata <= `IAC_ZERO32;
    endcase
  end
  else
    o_rdata <= `IAC_ZERO32;
end
endmodule

// ---- iac_capture_assertions.sv ----
// Checker for the interrupt-acknowledge capture block.
`include "iac_map.vh"
module iac_checker #(
  parameter CYC_LEN = 4,
  parameter GAP_LEN = 2
)(
  input wire i_sys_clk,
  input wire i_rst,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire o_interrupt_ack_cycle_n,
  input wire o_ack_second_cycle,
  input wire o_scope_sync_n,
  input wire o_common_handler
);
  timeunit 1ns;
  timeprecision 1ns;
  wire ack_n = o_interrupt_ack_cycle_n;
  wire frc = i_wr && i_addr == `IAC_REG_FORCE && i_wdata[0];
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Repetition counts assume the default bus cycle length of four.
  chk_ack_length: assert property (
    $fell(ack_n) |-> !ack_n[*8] ##1 ack_n) else $error("Ack length wrong.");
  chk_second_half: assert property (
    $fell(ack_n) |-> !o_ack_second_cycle[*4] ##1 o_ack_second_cycle[*4])
    else $error("Second cycle misplaced.");
  chk_sync_span: assert property (
    $fell(ack_n) && !o_scope_sync_n |-> !o_scope_sync_n[*8] ##1 o_scope_sync_n)
    else $error("Sync span wrong.");
  chk_sync_inside: assert property (
    !o_scope_sync_n |-> !ack_n) else $error("Sync outside ack.");
  chk_second_inside: assert property (
    o_ack_second_cycle |-> !ack_n) else $error("Second cycle outside ack.");
  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("Read data not idle.");
  chk_force_start: assert property (
    frc && ack_n && $past(ack_n) && $past(ack_n, 2) && $past(ack_n, 3)
    |=> !ack_n) else $error("Force did not start ack.");
  chk_handler_mode: assert property (
    $past(i_wr) && $past(i_addr) == `IAC_REG_CTRL
    |-> o_common_handler == !$past(i_wdata[2])) else $error("Handler wrong.");
  cov_force: cover property (frc && ack_n);
  cov_sync: cover property (!o_scope_sync_n);
  cov_second: cover property ($rose(o_ack_second_cycle));
endmodule
bind iac_capture iac_checker #(.CYC_LEN(CYC_LEN), .GAP_LEN(GAP_LEN)) chk_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_interrupt_ack_cycle_n(o_interrupt_ack_cycle_n),
  .o_ack_second_cycle(o_ack_second_cycle),
  .o_scope_sync_n(o_scope_sync_n), .o_common_handler(o_common_handler));

// ---- iac_board_model.sv ----
// Interrupt controllers of the board under test, answering acknowledges.
module iac_board_model (
  input wire logic i_sys_clk,
  input wire logic i_ack_n,
  input wire logic [7:0] i_type,
  input wire logic [2:0] i_casc,
  output logic [7:0] o_data,
  output logic [2:0] o_casc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_data = 8'h00;
  initial o_casc = 3'h0;
  // A released bus toggles, so a stale byte can never pass for a capture.
  always @(posedge i_sys_clk)
    if (i_ack_n)
    begin
      o_data <= ~o_data;
      o_casc <= ~o_casc;
    end
    else
    begin
      o_data <= i_type;
      o_casc <= i_casc;
    end
endmodule

// ---- tb_interrupt_ack_capture.sv ----
// Testbench for the interrupt-acknowledge capture block.
`include "iac_map.vh"
module tb_interrupt_ack_capture;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, req = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] typ = 8'h00;
  logic [2:0] cas = 3'h0;
  wire [31:0] rdata;
  wire [7:0] data;
  wire [2:0] casb;
  wire ack_n, second, sync_n, handler, irq;
  int error_cnt = 0, compares = 0;
  iac_capture uut (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .i_interrupt_request_input(req), .i_data_bus(data),
    .i_cascade_bus(casb), .o_interrupt_ack_cycle_n(ack_n),
    .o_ack_second_cycle(second), .o_scope_sync_n(sync_n),
    .o_common_handler(handler));
  iac_board_model brd (.i_sys_clk(clk), .i_ack_n(ack_n), .i_type(typ),
    .i_casc(cas), .o_data(data), .o_casc(casb));
  initial forever #5 clk = ~clk;
  // --------------------
  // Tasks
  // --------------------
  task automatic close_out;
    $display("Compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [3:0] a,
    input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  // Waits for one whole acknowledge sequence, low then high again.
  task automatic wait_ack;
    int n;
    bit seen;
    seen = 0;
    for (n = 0; n < 60 && !(seen && ack_n === 1'b1); n++)
    begin
      @(posedge clk);
      #1 seen |= (ack_n === 1'b0);
    end
    if (n == 60)
    begin
      error_cnt++;
      $display("ERROR ack_n expected sequence seen none");
      close_out;
    end
  endtask
  // --------------------
  // Sequence
  // --------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk("status", `IAC_REG_STATUS, 32'h2);
    rchk("unmapped", 4'hF, 32'h0);
    chk("handler", 32'h1, handler);
    wreg(`IAC_REG_IRQ_EN, 32'h1);
    wreg(`IAC_REG_CTRL, 32'h3);
    typ <= 8'hA5;
    cas <= 3'h5;
    req <= 1'b1;
    wait_ack;
    typ <= 8'h3C;
    repeat (20) @(posedge clk);
    chk("irq", 32'h1, irq);
    rchk("status", `IAC_REG_STATUS, 32'h1);
    rchk("type", `IAC_REG_TYPE_NOARM, 32'hA5);
    rchk("cascade", `IAC_REG_CASCADE, 32'h5);
    rchk("status", `IAC_REG_STATUS, 32'h1);
    rchk("type", `IAC_REG_TYPE_REARM, 32'hA5);
    wait_ack;
    req <= 1'b0;
    rchk("type", `IAC_REG_TYPE_NOARM, 32'h3C);
    wreg(`IAC_REG_IRQ_CLR, 32'h3);
    rchk("irq_stat", `IAC_REG_IRQ_STAT, 32'h0);
    chk("irq", 32'h0, irq);
    typ <= 8'hFF;
    cas <= 3'h0;
    wreg(`IAC_REG_FORCE, 32'h1);
    wait_ack;
    rchk("type", `IAC_REG_TYPE_NOARM, 32'hFF);
    rchk("cascade", `IAC_REG_CASCADE, 32'h0);
    $display("Capture test done");
    wreg(`IAC_REG_CTRL, 32'h4);
    rchk("type", `IAC_REG_TYPE_REARM, 32'hFF);
    req <= 1'b1;
    repeat (20) @(posedge clk);
    rchk("status", `IAC_REG_STATUS, 32'h2);
    chk("handler", 32'h0, handler);
    req <= 1'b0;
    cas <= 3'h7;
    wreg(`IAC_REG_FORCE, 32'h2);
    wait_ack;
    wait_ack;
    wreg(`IAC_REG_FORCE, 32'h4);
    repeat (20) @(posedge clk);
    rchk("status", `IAC_REG_STATUS, 32'h1);
    wreg(`IAC_REG_CTRL, 32'h1);
    rchk("status", `IAC_REG_STATUS, 32'h2);
    rchk("type", `IAC_REG_TYPE_NOARM, 32'h0);
    rchk("cascade", `IAC_REG_CASCADE, 32'h0);
    $display("Force test done");
    close_out;
  end
endmodule
